// File: core/spx_pkg.sv
package spx_pkg;

  // ************************************************************
  // register map: word indexes, byte address is four times index
  // ************************************************************
  localparam logic [7:0]  CTRL_INDEX   = 8'h10;
  localparam logic [7:0]  STAT_INDEX   = 8'h11;
  localparam logic [7:0]  DATA_INDEX   = 8'h12;
  localparam logic [11:0] CTRL_ADDR    = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [11:0] STAT_ADDR    = {2'h0, STAT_INDEX, 2'h0};
  localparam logic [11:0] DATA_ADDR    = {2'h0, DATA_INDEX, 2'h0};

  // ************************************************************
  // port control register fields
  // ************************************************************
  localparam int CTRL_RX_IRQ_EN  = 7;
  localparam int CTRL_MASTER     = 5;
  localparam int CTRL_CPOL       = 4;
  localparam int CTRL_CPHA       = 3;
  localparam int CTRL_WIRED_OR   = 2;
  localparam int CTRL_ENABLE     = 1;
  localparam int CTRL_TX_IRQ_EN  = 0;
  localparam logic [7:0] CTRL_RESET = 8'h28;

  // ************************************************************
  // port status and control register fields
  // ************************************************************
  localparam int STAT_RX_FULL    = 7;
  localparam int STAT_ERR_IRQ_EN = 6;
  localparam int STAT_OVERFLOW   = 5;
  localparam int STAT_MODE_FAULT = 4;
  localparam int STAT_TX_EMPTY   = 3;
  localparam int STAT_FAULT_EN   = 2;
  localparam int STAT_RATE_HI    = 1;
  localparam int STAT_RATE_LO    = 0;
  localparam logic [7:0] STAT_RESET = 8'h08;

  // ************************************************************
  // master rate divisors
  // ************************************************************
  localparam logic [7:0] DIV_SEL0 = 8'h02;
  localparam logic [7:0] DIV_SEL1 = 8'h08;
  localparam logic [7:0] DIV_SEL2 = 8'h20;
  localparam logic [7:0] DIV_SEL3 = 8'h80;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic       rxLoad;
    logic [7:0] rxByte;
    logic       txTake;
    logic       busy;
  } spx_core_in_s;

  typedef struct packed {
    logic       portEnable;
    logic       masterSelect;
    logic       clockPolarity;
    logic       clockPhase;
    logic       wiredOrMode;
    logic       pullupEnable;
    logic       ssUsedBySpi;
    logic [7:0] rateDivisor;
    logic       txValid;
    logic [7:0] txByte;
  } spx_core_out_s;

  typedef struct packed {
    logic       rxIrqEnable;
    logic       masterSelect;
    logic       clockPolarity;
    logic       clockPhase;
    logic       wiredOrMode;
    logic       portEnable;
    logic       txIrqEnable;
    logic       rxFull;
    logic       errIrqEnable;
    logic       overflow;
    logic       modeFault;
    logic       txEmpty;
    logic       modeFaultEnable;
    logic [1:0] rateSelect;
    logic       armRx;
    logic       armOvr;
    logic       armFault;
    logic       ssSync1;
    logic       ssSync2;
    logic       ssPrev;
  } spx_state_s;

endpackage : spx_pkg

// File: core/spx_reg_ctrl.sv
// Functional notes
// - receive irq enable gates rx-full request
// - master select, one is master, resets set
// - clock polarity sets idle level, reset clear
// - clock phase selects edge timing, resets one
// - wired-or disables pullups, open-drain pins
// - port enable on; clearing gives partial reset
// - transmit irq enable gates tx-empty request
// - rx-full sets when byte reaches receive register
// - rx-full clears by status then data read
// - error irq enable gates overflow, mode fault
// - overflow keeps old byte, drops new
// - overflow clears by status then data read
// - slave select rising mid-transfer faults slave
// - slave select low faults master
// - mode fault clears by status then control write
// - tx-empty sets on handoff, reset sets
// - data write clears tx-empty
// - fault enable permits flag, clearing keeps flag
// - disabled detection leaves select unused in master mode
// - rate bits pick divisor 2/8/32/128
// - separate tx/rx data, not reset
//
// Design decision made here: register access over APB.
module spx_reg_ctrl (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  slaveSelectN,
  input  wire spx_pkg::spx_core_in_s coreIn,
  output spx_pkg::spx_core_out_s     coreOut,
  output logic                       irq
);

  // ************************************************************
  // state
  // ************************************************************
  spx_pkg::spx_state_s st;
  spx_pkg::spx_state_s next_st;
  logic [7:0]          rxData;
  logic [7:0]          txData;

  logic accessDone;
  logic ctrlWrite;
  logic statRead;
  logic statWrite;
  logic dataRead;
  logic dataWrite;
  logic mapped;
  logic ssLow;
  logic ssRise;
  logic masterFault;
  logic slaveFault;
  logic rxAccept;
  logic [7:0] ctrlView;
  logic [7:0] statView;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  function automatic logic [7:0] rateDiv(input logic [1:0] sel);
    case (sel)
      2'h0:    rateDiv = spx_pkg::DIV_SEL0;
      2'h1:    rateDiv = spx_pkg::DIV_SEL1;
      2'h2:    rateDiv = spx_pkg::DIV_SEL2;
      default: rateDiv = spx_pkg::DIV_SEL3;
    endcase
  endfunction : rateDiv

  // ************************************************************
  // apb decode
  // ************************************************************
  // zero wait states keeps the read side effects on a single edge
  assign pready     = 1'b1;
  assign mapped     = (paddr == spx_pkg::CTRL_ADDR) || (paddr == spx_pkg::STAT_ADDR) ||
                      (paddr == spx_pkg::DATA_ADDR);
  assign pslverr    = psel & penable & ~mapped;
  assign accessDone = psel & penable;
  assign ctrlWrite  = accessDone & pwrite & (paddr == spx_pkg::CTRL_ADDR);
  assign statWrite  = accessDone & pwrite & (paddr == spx_pkg::STAT_ADDR);
  assign statRead   = accessDone & ~pwrite & (paddr == spx_pkg::STAT_ADDR);
  assign dataWrite  = accessDone & pwrite & (paddr == spx_pkg::DATA_ADDR);
  assign dataRead   = accessDone & ~pwrite & (paddr == spx_pkg::DATA_ADDR);

  always_comb begin
    ctrlView = 8'h00;
    ctrlView[spx_pkg::CTRL_RX_IRQ_EN] = st.rxIrqEnable;
    ctrlView[spx_pkg::CTRL_MASTER]    = st.masterSelect;
    ctrlView[spx_pkg::CTRL_CPOL]      = st.clockPolarity;
    ctrlView[spx_pkg::CTRL_CPHA]      = st.clockPhase;
    ctrlView[spx_pkg::CTRL_WIRED_OR]  = st.wiredOrMode;
    ctrlView[spx_pkg::CTRL_ENABLE]    = st.portEnable;
    ctrlView[spx_pkg::CTRL_TX_IRQ_EN] = st.txIrqEnable;
    statView = 8'h00;
    statView[spx_pkg::STAT_RX_FULL]    = st.rxFull;
    statView[spx_pkg::STAT_ERR_IRQ_EN] = st.errIrqEnable;
    statView[spx_pkg::STAT_OVERFLOW]   = st.overflow;
    statView[spx_pkg::STAT_MODE_FAULT] = st.modeFault;
    statView[spx_pkg::STAT_TX_EMPTY]   = st.txEmpty;
    statView[spx_pkg::STAT_FAULT_EN]   = st.modeFaultEnable;
    statView[spx_pkg::STAT_RATE_HI]    = st.rateSelect[1];
    statView[spx_pkg::STAT_RATE_LO]    = st.rateSelect[0];
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        spx_pkg::CTRL_ADDR: prdata = {24'h00_0000, ctrlView};
        spx_pkg::STAT_ADDR: prdata = {24'h00_0000, statView};
        spx_pkg::DATA_ADDR: prdata = {24'h00_0000, rxData};
        default:            prdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // slave select and fault detection
  // ************************************************************
  assign ssLow       = ~st.ssSync2;
  assign ssRise      = st.ssSync2 & ~st.ssPrev;
  // select is ignored unless detection is enabled in master mode
  assign masterFault = st.portEnable & st.masterSelect & st.modeFaultEnable & ssLow;
  assign slaveFault  = st.portEnable & ~st.masterSelect & st.modeFaultEnable &
                       ssRise & coreIn.busy;
  assign rxAccept    = coreIn.rxLoad & ~st.rxFull;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st         = st;
    next_st.ssSync1 = slaveSelectN;
    next_st.ssSync2 = st.ssSync1;
    next_st.ssPrev  = st.ssSync2;

    if (ctrlWrite) begin
      next_st.rxIrqEnable   = pwdata[spx_pkg::CTRL_RX_IRQ_EN];
      next_st.masterSelect  = pwdata[spx_pkg::CTRL_MASTER];
      next_st.clockPolarity = pwdata[spx_pkg::CTRL_CPOL];
      next_st.clockPhase    = pwdata[spx_pkg::CTRL_CPHA];
      next_st.wiredOrMode   = pwdata[spx_pkg::CTRL_WIRED_OR];
      next_st.portEnable    = pwdata[spx_pkg::CTRL_ENABLE];
      next_st.txIrqEnable   = pwdata[spx_pkg::CTRL_TX_IRQ_EN];
    end
    if (statWrite) begin
      next_st.errIrqEnable    = pwdata[spx_pkg::STAT_ERR_IRQ_EN];
      next_st.modeFaultEnable = pwdata[spx_pkg::STAT_FAULT_EN];
      next_st.rateSelect      = pwdata[spx_pkg::STAT_RATE_HI:spx_pkg::STAT_RATE_LO];
    end

    // first step of each two-step clear: status read seeing the flag
    if (statRead) begin
      next_st.armRx    = st.rxFull;
      next_st.armOvr   = st.overflow;
      next_st.armFault = st.modeFault;
    end

    if (dataRead) begin
      next_st.armRx  = 1'b0;
      next_st.armOvr = 1'b0;
      if (st.armRx) begin
        next_st.rxFull = 1'b0;
      end
      if (st.armOvr) begin
        next_st.overflow = 1'b0;
      end
    end
    if (ctrlWrite) begin
      next_st.armFault = 1'b0;
      if (st.armFault) begin
        next_st.modeFault = 1'b0;
      end
    end

    // hardware events win over a clear in the same cycle
    if (coreIn.rxLoad) begin
      if (st.rxFull) begin
        next_st.overflow = 1'b1;
      end else begin
        next_st.rxFull = 1'b1;
      end
    end
    if (dataWrite) begin
      next_st.txEmpty = 1'b0;
    end
    if (coreIn.txTake) begin
      next_st.txEmpty = 1'b1;
    end
    if (masterFault || slaveFault) begin
      next_st.modeFault = 1'b1;
    end
    // a master that sees another master drive select stops driving
    if (masterFault) begin
      next_st.portEnable = 1'b0;
    end
    // partial reset: flags stay readable, transmitter reads empty
    if (!st.portEnable) begin
      next_st.txEmpty = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st                 <= '0;
      st.masterSelect    <= 1'b1;
      st.clockPhase      <= 1'b1;
      st.txEmpty         <= 1'b1;
      st.ssSync1         <= 1'b1;
      st.ssSync2         <= 1'b1;
      st.ssPrev          <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // data registers, deliberately outside reset
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rxAccept) begin
      rxData <= coreIn.rxByte;
    end
    if (dataWrite) begin
      txData <= pwdata[7:0];
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    coreOut.portEnable    = st.portEnable;
    coreOut.masterSelect  = st.masterSelect;
    coreOut.clockPolarity = st.clockPolarity;
    coreOut.clockPhase    = st.clockPhase;
    coreOut.wiredOrMode   = st.wiredOrMode;
    coreOut.pullupEnable  = ~st.wiredOrMode;
    coreOut.ssUsedBySpi   = st.portEnable & (~st.masterSelect | st.modeFaultEnable);
    coreOut.rateDivisor   = rateDiv(st.rateSelect);
    coreOut.txValid       = ~st.txEmpty;
    coreOut.txByte        = txData;
  end

  assign irq = (st.rxFull & st.rxIrqEnable) | (st.txEmpty & st.txIrqEnable) |
               ((st.overflow | st.modeFault) & st.errIrqEnable);

  // ************************************************************
  // checks
  // ************************************************************
  property p_rxFullSet;
    coreIn.rxLoad && !st.rxFull |=> st.rxFull && rxData == $past(coreIn.rxByte);
  endproperty
  a_rxFullSet: assert property (p_rxFullSet) else $error("rx full not set on load");

  property p_overflowKeeps;
    coreIn.rxLoad && st.rxFull |=> st.overflow && $stable(rxData);
  endproperty
  a_overflowKeeps: assert property (p_overflowKeeps) else $error("overflow handling wrong");

  property p_rxClearSeq;
    $fell(st.rxFull) |-> $past(dataRead) && $past(st.armRx);
  endproperty
  a_rxClearSeq: assert property (p_rxClearSeq) else $error("rx full cleared out of sequence");

  property p_ovrClearSeq;
    $fell(st.overflow) |-> $past(dataRead) && $past(st.armOvr);
  endproperty
  a_ovrClearSeq: assert property (p_ovrClearSeq) else $error("overflow cleared out of sequence");

  property p_faultClearSeq;
    $fell(st.modeFault) |-> $past(ctrlWrite) && $past(st.armFault);
  endproperty
  a_faultClearSeq: assert property (p_faultClearSeq) else $error("mode fault cleared out of sequence");

  property p_masterFault;
    st.portEnable && st.masterSelect && st.modeFaultEnable && !st.ssSync2 |=> st.modeFault && !st.portEnable;
  endproperty
  a_masterFault: assert property (p_masterFault) else $error("master fault not flagged");

  property p_txEmptyClr;
    dataWrite && !coreIn.txTake && st.portEnable |=> !st.txEmpty && coreOut.txValid;
  endproperty
  a_txEmptyClr: assert property (p_txEmptyClr) else $error("tx empty not cleared by write");

  property p_txEmptySet;
    coreIn.txTake |=> st.txEmpty;
  endproperty
  a_txEmptySet: assert property (p_txEmptySet) else $error("tx empty not set on handoff");

  property p_irqRx;
    st.rxFull && st.rxIrqEnable |-> irq;
  endproperty
  a_irqRx: assert property (p_irqRx) else $error("rx request missing");

  property p_irqQuiet;
    !st.rxIrqEnable && !st.txIrqEnable && !st.errIrqEnable |-> !irq;
  endproperty
  a_irqQuiet: assert property (p_irqQuiet) else $error("request while all disabled");

  property p_faultHold;
    st.modeFault && statWrite && !pwdata[spx_pkg::STAT_FAULT_EN] && !ctrlWrite |=> st.modeFault;
  endproperty
  a_faultHold: assert property (p_faultHold) else $error("disabling detection cleared fault");

  property p_rate;
    st.rateSelect == 2'h1 |-> coreOut.rateDivisor == 8'h08;
  endproperty
  a_rate: assert property (p_rate) else $error("divisor wrong");

  property p_slaveFault;
    st.portEnable && !st.masterSelect && st.modeFaultEnable && ssRise && coreIn.busy |=> st.modeFault;
  endproperty
  a_slaveFault: assert property (p_slaveFault) else $error("slave fault not flagged");

  property p_faultGated;
    !st.modeFault && !st.modeFaultEnable |=> !st.modeFault;
  endproperty
  a_faultGated: assert property (p_faultGated) else $error("fault set with detection off");

  property p_rxFullRise;
    $rose(st.rxFull) |-> $past(coreIn.rxLoad);
  endproperty
  a_rxFullRise: assert property (p_rxFullRise) else $error("rx full set without a load");

  property p_ovrRise;
    $rose(st.overflow) |-> $past(coreIn.rxLoad) && $past(st.rxFull);
  endproperty
  a_ovrRise: assert property (p_ovrRise) else $error("overflow set without a second load");

  property p_txEmptyRise;
    $rose(st.txEmpty) |-> $past(coreIn.txTake) || !$past(st.portEnable);
  endproperty
  a_txEmptyRise: assert property (p_txEmptyRise) else $error("tx empty set without handoff");

  property p_disabledTxEmpty;
    !st.portEnable |=> st.txEmpty;
  endproperty
  a_disabledTxEmpty: assert property (p_disabledTxEmpty) else $error("disabled port not empty");

  property p_irqTx;
    st.txEmpty && st.txIrqEnable |-> irq;
  endproperty
  a_irqTx: assert property (p_irqTx) else $error("tx request missing");

  property p_irqErr;
    (st.overflow || st.modeFault) && st.errIrqEnable |-> irq;
  endproperty
  a_irqErr: assert property (p_irqErr) else $error("error request missing");

  property p_ctrlFields;
    ctrlWrite |=> st.clockPolarity == $past(pwdata[spx_pkg::CTRL_CPOL]) &&
                  st.clockPhase == $past(pwdata[spx_pkg::CTRL_CPHA]);
  endproperty
  a_ctrlFields: assert property (p_ctrlFields) else $error("polarity or phase not written");

  property p_wiredOr;
    ctrlWrite |=> coreOut.pullupEnable != $past(pwdata[spx_pkg::CTRL_WIRED_OR]);
  endproperty
  a_wiredOr: assert property (p_wiredOr) else $error("pullup not following wired-or mode");

  property p_rateTop;
    st.rateSelect == 2'h3 |-> coreOut.rateDivisor == 8'h80;
  endproperty
  a_rateTop: assert property (p_rateTop) else $error("top divisor wrong");

  property p_txData;
    dataWrite |=> coreOut.txByte == $past(pwdata[7:0]);
  endproperty
  a_txData: assert property (p_txData) else $error("transmit byte not stored");

endmodule : spx_reg_ctrl

// File: testbench/spx_far_end.sv
module spx_far_end (
  input  wire logic                   clk,
  input  wire spx_pkg::spx_core_out_s coreOut,
  output spx_pkg::spx_core_in_s       coreIn,
  output logic                        slaveSelectN
);
  timeunit 1ns;
  timeprecision 100ps;

  // select has a pull-up: idle high between bytes
  initial begin
    coreIn       = '0;
    slaveSelectN = 1'h1;
  end

  // ************************************************************
  // shift core and far device actions
  // ************************************************************
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    coreIn.rxLoad <= 1'h1;
    coreIn.rxByte <= b;
    @(posedge clk);
    coreIn.rxLoad <= 1'h0;
    // byte no longer valid: show its inverse, not a stale copy
    coreIn.rxByte <= ~b;
  endtask : send

  task automatic take();
    @(posedge clk);
    if (coreOut.txValid === 1'h1) begin
      coreIn.txTake <= 1'h1;
      @(posedge clk);
      coreIn.txTake <= 1'h0;
    end
  endtask : take

  task automatic drive(input logic ss, input logic busy);
    @(posedge clk);
    slaveSelectN <= ss;
    coreIn.busy  <= busy;
  endtask : drive
endmodule : spx_far_end

// File: testbench/spi_register_control_tb.sv
module spi_register_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   clk = 1'h0;
  logic                   resetn = 1'h0;
  logic                   psel = 1'h0;
  logic                   penable = 1'h0;
  logic                   pwrite = 1'h0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   lastErr;
  logic                   slaveSelectN;
  spx_pkg::spx_core_in_s  coreIn;
  spx_pkg::spx_core_out_s coreOut;
  logic                   irq;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  int                     cycles = 0;

  always #5 clk = ~clk;

  spx_reg_ctrl dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slaveSelectN(slaveSelectN), .coreIn(coreIn), .coreOut(coreOut), .irq(irq));

  spx_far_end far (.clk(clk), .coreOut(coreOut), .coreIn(coreIn), .slaveSelectN(slaveSelectN));

  // ************************************************************
  // bus and compare helpers
  // ************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    r       = prdata;
    lastErr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'h1, a, {24'h0, d}, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] r;
    apb(1'h0, a, 32'h0, r);
    chk(r, {24'h0, exp});
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    rd(spx_pkg::CTRL_ADDR, 8'h28);
    rd(spx_pkg::STAT_ADDR, 8'h08);
    chk(irq, 1'h0);
    rd(12'h0fc, 8'h00);
    chk(lastErr, 1'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx();
    wr(spx_pkg::CTRL_ADDR, 8'h2b);
    settle(1);
    chk(irq, 1'h1);
    wr(spx_pkg::DATA_ADDR, 8'ha5);
    settle(1);
    chk({coreOut.txValid, coreOut.txByte, irq}, {1'h1, 8'ha5, 1'h0});
    rd(spx_pkg::STAT_ADDR, 8'h00);
    far.take();
    settle(1);
    chk(irq, 1'h1);
    rd(spx_pkg::STAT_ADDR, 8'h08);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_ctrl();
    logic [7:0] div [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
    for (int i = 0; i < 4; i++) begin
      wr(spx_pkg::STAT_ADDR, 8'(i));
      settle(1);
      chk(coreOut.rateDivisor, div[i]);
      rd(spx_pkg::STAT_ADDR, 8'h08 | 8'(i));
    end
    wr(spx_pkg::CTRL_ADDR, 8'hff);
    settle(1);
    chk({coreOut.pullupEnable, coreOut.wiredOrMode, coreOut.clockPolarity}, 3'h3);
    rd(spx_pkg::CTRL_ADDR, 8'hbf);
    wr(spx_pkg::CTRL_ADDR, 8'h02);
    settle(1);
    chk({coreOut.masterSelect, coreOut.clockPhase, coreOut.portEnable}, 3'h1);
    $display("test control done");
  endtask : t_ctrl

  task automatic t_rx();
    wr(spx_pkg::STAT_ADDR, 8'h00);
    wr(spx_pkg::CTRL_ADDR, 8'haa);
    far.send(8'h3c);
    settle(1);
    chk(irq, 1'h1);
    rd(spx_pkg::DATA_ADDR, 8'h3c);
    rd(spx_pkg::STAT_ADDR, 8'h88);
    far.send(8'hc3);
    rd(spx_pkg::STAT_ADDR, 8'ha8);
    rd(spx_pkg::DATA_ADDR, 8'h3c);
    rd(spx_pkg::STAT_ADDR, 8'h08);
    settle(1);
    chk(irq, 1'h0);
    $display("test receive done");
  endtask : t_rx

  task automatic t_fault();
    wr(spx_pkg::CTRL_ADDR, 8'h2a);
    wr(spx_pkg::STAT_ADDR, 8'h44);
    far.drive(1'h0, 1'h0);
    settle(4);
    chk(irq, 1'h1);
    rd(spx_pkg::STAT_ADDR, 8'h5c);
    rd(spx_pkg::CTRL_ADDR, 8'h28);
    wr(spx_pkg::DATA_ADDR, 8'h55);
    rd(spx_pkg::STAT_ADDR, 8'h5c);
    far.drive(1'h1, 1'h0);
    wr(spx_pkg::STAT_ADDR, 8'h40);
    rd(spx_pkg::STAT_ADDR, 8'h58);
    wr(spx_pkg::CTRL_ADDR, 8'h2a);
    rd(spx_pkg::STAT_ADDR, 8'h48);
    far.drive(1'h0, 1'h0);
    settle(4);
    rd(spx_pkg::STAT_ADDR, 8'h48);
    rd(spx_pkg::CTRL_ADDR, 8'h2a);
    chk(coreOut.ssUsedBySpi, 1'h0);
    // slave: select rising while a byte is in flight
    wr(spx_pkg::CTRL_ADDR, 8'h0a);
    wr(spx_pkg::STAT_ADDR, 8'h44);
    far.drive(1'h0, 1'h1);
    settle(4);
    rd(spx_pkg::STAT_ADDR, 8'h4c);
    chk(coreOut.ssUsedBySpi, 1'h1);
    far.drive(1'h1, 1'h1);
    settle(4);
    rd(spx_pkg::STAT_ADDR, 8'h5c);
    far.drive(1'h1, 1'h0);
    $display("test mode fault done");
  endtask : t_fault

  // ************************************************************
  // run control
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    t_reset();
    t_tx();
    t_ctrl();
    t_rx();
    t_fault();
    complete_run();
  end
endmodule : spi_register_control_tb
